/* tmc_pkg.sv */
// Package for the timer main counter: register map, fields and types
package tmc_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CNT  = 4'h4;
  localparam logic [3:0] ADDR_MOD  = 4'h8;
  localparam int CTRL_CLKSEL = 0;
  localparam int CTRL_CPWM   = 2;
  localparam int CTRL_OVIE   = 3;
  localparam int CTRL_OVF    = 7;
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_BUS = 2'h1;
  localparam logic [1:0] SRC_FIX = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] MOD_RESET = 16'h0000;
  localparam logic [15:0] CNT_FULL  = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic       overflowIe;
    logic       centerAligned;
    logic [1:0] clockSourceSelect;
  } tmc_ctrl_t;
endpackage

/* tmc_timer_main_counter.sv */
// Timer main counter with AXI4-Lite register slave
`timescale 1ns/10ps
module tmc_timer_main_counter #(
  parameter int ADDR_W = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              debugActive,
  input  wire logic              stopMode,
  input  wire logic              fixedFrequencyClock,
  input  wire logic              channelZeroPin,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   overflowIrq,
  output logic [15:0]            counterValue
);
  // Offsets decode on four address bits, so narrower buses cannot work
  if (ADDR_W < 4) begin : g_addr_check
    $error("ADDR_W must be at least 4");
  end

  tmc_pkg::tmc_ctrl_t ctrl;
  logic [15:0] modulusValue;
  logic        counterOverflowFlag;
  logic        countDown;
  logic        flagSeen;
  logic        fixPrev;
  logic        pinPrev;
  logic        tick;
  logic [15:0] terminal;
  logic        wrap;
  logic        reverse;
  logic        ovfEvent;
  logic        haveAw;
  logic        haveW;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        doWrite;
  logic        wrOk;
  logic        wrCnt;
  logic        wrCtrl;
  logic        rdCtrl;

  // Edge memory for the slow clock sources
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fixPrev <= 1'b0;
      pinPrev <= 1'b0;
    end else begin
      fixPrev <= fixedFrequencyClock;
      pinPrev <= channelZeroPin;
    end
  end

  // Counting tick: one bus cycle per rising edge of the chosen source
  always_comb begin
    case (ctrl.clockSourceSelect)
      tmc_pkg::SRC_BUS: tick = 1'b1;
      tmc_pkg::SRC_FIX: tick = fixedFrequencyClock & ~fixPrev;
      tmc_pkg::SRC_EXT: tick = channelZeroPin & ~pinPrev;
      default:          tick = 1'b0;
    endcase
    if (debugActive || stopMode) begin
      tick = 1'b0;
    end
  end

  // Terminal count: zero modulus means free running to all ones
  assign terminal = (modulusValue == tmc_pkg::MOD_RESET) ? tmc_pkg::CNT_FULL : modulusValue;
  assign wrap     = tick && !ctrl.centerAligned && counterValue == terminal;
  assign reverse  = tick && ctrl.centerAligned && !countDown && counterValue >= terminal;
  assign ovfEvent = wrap || reverse;

  // Write path: address and data captured in either order
  assign doWrite = haveAw && haveW && !s_axi_bvalid;
  assign wrOk    = awAddr[3:2] != 2'b11 && awAddr[1:0] == 2'b00;
  assign wrCnt   = doWrite && awAddr[3:0] == tmc_pkg::ADDR_CNT;
  assign wrCtrl  = doWrite && awAddr[3:0] == tmc_pkg::ADDR_CTRL;
  assign rdCtrl  = s_axi_arvalid && s_axi_arready && s_axi_araddr[3:0] == tmc_pkg::ADDR_CTRL;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      haveAw        <= 1'b0;
      haveW         <= 1'b0;
      awAddr        <= '0;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= tmc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw        <= 1'b1;
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveW        <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        haveAw       <= 1'b0;
        haveW        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrOk ? tmc_pkg::RESP_OKAY : tmc_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control and modulus registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl         <= '0;
      modulusValue <= tmc_pkg::MOD_RESET;
    end else if (doWrite) begin
      if (wStrb[0] && awAddr[3:0] == tmc_pkg::ADDR_CTRL) begin
        ctrl.clockSourceSelect <= wData[tmc_pkg::CTRL_CLKSEL +: 2];
        ctrl.centerAligned     <= wData[tmc_pkg::CTRL_CPWM];
        ctrl.overflowIe        <= wData[tmc_pkg::CTRL_OVIE];
      end
      // Each byte lane lands on its own strobe
      if (wStrb[0] && awAddr[3:0] == tmc_pkg::ADDR_MOD) begin
        modulusValue[7:0] <= wData[7:0];
      end
      if (wStrb[1] && awAddr[3:0] == tmc_pkg::ADDR_MOD) begin
        modulusValue[15:8] <= wData[15:8];
      end
    end
  end

  // Main counter and direction
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      counterValue <= tmc_pkg::CNT_RESET;
      countDown    <= 1'b0;
    end else if (wrCnt && wStrb[1:0] != 2'b00) begin
      counterValue <= tmc_pkg::CNT_RESET;
      countDown    <= 1'b0;
    end else if (tick) begin
      if (!ctrl.centerAligned) begin
        counterValue <= wrap ? tmc_pkg::CNT_RESET : counterValue + 16'h0001;
        countDown    <= 1'b0;
      end else if (reverse) begin
        counterValue <= counterValue - 16'h0001;
        countDown    <= 1'b1;
      end else if (countDown && counterValue == tmc_pkg::CNT_RESET) begin
        // zero held one tick then up
        counterValue <= 16'h0001;
        countDown    <= 1'b0;
      end else begin
        counterValue <= countDown ? counterValue - 16'h0001 : counterValue + 16'h0001;
      end
    end
  end

  // Overflow flag: set beats clear so no event is lost
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      counterOverflowFlag <= 1'b0;
      flagSeen            <= 1'b0;
    end else begin
      if (rdCtrl) begin
        flagSeen <= counterOverflowFlag;
      end
      if (ovfEvent) begin
        counterOverflowFlag <= 1'b1;
      end else if (wrCtrl && wStrb[0] && flagSeen && !wData[tmc_pkg::CTRL_OVF]) begin
        counterOverflowFlag <= 1'b0;
        flagSeen            <= 1'b0;
      end
    end
  end

  // Interrupt request follows the flag one cycle later
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      overflowIrq <= 1'b0;
    end else begin
      overflowIrq <= counterOverflowFlag && ctrl.overflowIe;
    end
  end

  // Read path: one read at a time, answer one cycle after address
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tmc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= tmc_pkg::RESP_OKAY;
      case (s_axi_araddr[3:0])
        tmc_pkg::ADDR_CTRL: s_axi_rdata <= {24'h00_0000, counterOverflowFlag, 3'b000,
                                            ctrl.overflowIe, ctrl.centerAligned,
                                            ctrl.clockSourceSelect};
        tmc_pkg::ADDR_CNT:  s_axi_rdata <= {16'h0000, counterValue};
        tmc_pkg::ADDR_MOD:  s_axi_rdata <= {16'h0000, modulusValue};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= tmc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks on counter behaviour
  // reset state
  a_reset_source_off: assert property (@(posedge clk_sys) $rose(nrst) |-> ctrl.clockSourceSelect == 2'h0)
    else $error("clock source not off after reset");
  a_debug_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    debugActive && !wrCnt |=> $stable(counterValue))
    else $error("counter moved in debug");
  a_stop_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    stopMode && !wrCnt |=> $stable(counterValue))
    else $error("counter moved in stop");
  a_up_wrap: assert property (@(posedge clk_sys) disable iff (!nrst)
    wrap && !wrCnt |=> counterValue == 16'h0000)
    else $error("up counter did not wrap");
  a_wrap_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
    wrap |=> counterOverflowFlag)
    else $error("flag missing on wrap");
  a_reverse_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
    reverse && !wrCnt |=> counterOverflowFlag && countDown)
    else $error("flag missing on reversal");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (!nrst)
    1'b1 |=> overflowIrq == ($past(counterOverflowFlag) && $past(ctrl.overflowIe)))
    else $error("request does not follow flag");
  a_manual_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    wrCnt && wStrb[1:0] != 2'b00 |=> counterValue == 16'h0000 && !countDown)
    else $error("counter write did not clear");
  a_bottom_turn: assert property (@(posedge clk_sys) disable iff (!nrst)
    tick && ctrl.centerAligned && countDown && counterValue == 16'h0000 && !wrCnt
    |=> counterValue == 16'h0001 && !countDown)
    else $error("no turn at zero");
  // flag kept unless armed by a read
  a_flag_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
    counterOverflowFlag && !flagSeen |=> counterOverflowFlag)
    else $error("flag cleared without a read");
endmodule

/* tb_timer_main_counter.sv */
// Self-checking bench for the timer main counter
`timescale 1ns/10ps
module tb_timer_main_counter;
  logic        clk_sys, nrst, debugActive, stopMode, fixedFrequencyClock, channelZeroPin;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        overflowIrq;
  logic [15:0] counterValue;
  logic [1:0]  wrResp;
  int          num_errors, checked;

  tmc_timer_main_counter DUT (.clk_sys, .nrst, .debugActive, .stopMode, .fixedFrequencyClock,
    .channelZeroPin, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .overflowIrq, .counterValue);

  // 25 MHz clock
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    // Ready is raised on every call and never lowered, so each response is taken as it appears
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    wrResp = s_axi_bresp;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
    d = s_axi_rdata;
  endtask

  // Bus-clocked run from a frozen, cleared count, tracked cycle by cycle
  task automatic run(input logic cp, ie, input logic [15:0] m, input int n);
    logic [15:0] e;
    logic        up, fl, iq;
    debugActive <= 1;
    rd(tmc_pkg::ADDR_CTRL, v);
    wr(tmc_pkg::ADDR_MOD, {16'h0000, m});
    wr(tmc_pkg::ADDR_CTRL, {28'h0000_000, ie, cp, tmc_pkg::SRC_BUS});
    wr(tmc_pkg::ADDR_CNT, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    rd(tmc_pkg::ADDR_CTRL, v);
    chk("flag cleared", v[7], 0);
    chk("frozen count", counterValue, 0);
    debugActive <= 0;
    e = 0;
    up = 1;
    fl = 0;
    iq = 0;
    repeat (n) begin
      @(negedge clk_sys);
      chk("count", counterValue, e);
      chk("irq", overflowIrq, iq);
      iq = fl & ie;
      if (e == m) begin
        fl = 1;
        up = 0;
      end else if (e == 0) up = 1;
      e = (!cp && e == m) ? 16'h0000 : (up || !cp) ? e + 1 : e - 1;
    end
    rd(tmc_pkg::ADDR_CTRL, v);
    chk("flag polled", v[7], 1);
    $display("run done mode %0d", cp);
  endtask

  // Three fixed-clock and two pin edges at a quarter of the bus rate
  task automatic src(input logic [1:0] s, input logic [15:0] ex);
    wr(tmc_pkg::ADDR_MOD, 32'h0000_0000);
    wr(tmc_pkg::ADDR_CTRL, {30'h0000_0000, s});
    wr(tmc_pkg::ADDR_CNT, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      if (i < 3) fixedFrequencyClock <= 1;
      else channelZeroPin <= 1;
      repeat (2) @(posedge clk_sys);
      fixedFrequencyClock <= 0;
      channelZeroPin <= 0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
    chk("edge count", counterValue, ex);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Generous span for all runs
  initial begin
    #800000;
    num_errors++;
    report_and_stop;
  end

  initial begin
    {nrst, debugActive, stopMode, fixedFrequencyClock, channelZeroPin} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge clk_sys);
    nrst <= 1;
    @(posedge clk_sys);
    rd(tmc_pkg::ADDR_CTRL, v);
    chk("ctrl reset", v, 0);
    rd(4'hC, v);
    chk("unmapped resp", s_axi_rresp, tmc_pkg::RESP_SLVERR);
    chk("count reset", counterValue, 0);
    wr(tmc_pkg::ADDR_MOD, 32'h0000_1234);
    chk("wr resp", wrResp, tmc_pkg::RESP_OKAY);
    rd(tmc_pkg::ADDR_MOD, v);
    chk("mod both bytes", v, 32'h0000_1234);
    wr(4'hC, 32'h0000_0000);
    chk("unmapped wr resp", wrResp, tmc_pkg::RESP_SLVERR);
    $display("reset test done");
    run(0, 1, 16'h0003, 10);
    run(1, 1, 16'h0003, 14);
    run(1, 0, 16'h0001, 8);
    // Stop mode freezes the count
    stopMode <= 1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    v = counterValue;
    repeat (4) @(negedge clk_sys);
    chk("stop hold", counterValue, v);
    @(posedge clk_sys);
    stopMode <= 0;
    $display("stop test done");
    src(tmc_pkg::SRC_OFF, 0);
    src(tmc_pkg::SRC_FIX, 3);
    src(tmc_pkg::SRC_EXT, 2);
    $display("source test done");
    report_and_stop;
  end
endmodule
